// [include/clock_config_defs.svh]
`ifndef CLOCK_CONFIG_DEFS_SVH
`define CLOCK_CONFIG_DEFS_SVH
`define OFS_USB_PLL_CONTROL 12'h010
`define OFS_USB_PLL_STATUS 12'h014
`define OFS_USB_PLL_SOURCE_SELECT 12'h048
`define OFS_USB_PLL_SOURCE_UPDATE 12'h04c
`define OFS_MAIN_SOURCE_SELECT 12'h070
`define OFS_MAIN_SOURCE_UPDATE 12'h074
`define OFS_BUS_CLOCK_GATING 12'h080
`define OFS_SSP0_DIVIDER 12'h094
`define OFS_UART_DIVIDER 12'h098
`define OFS_SSP1_DIVIDER 12'h09c
`define OFS_TRACE_DIVIDER 12'h0ac
`define OFS_TICK_DIVIDER 12'h0b0
`define OFS_USB_CLOCK_SOURCE_SELECT 12'h0c0
`define OFS_USB_CLOCK_SOURCE_UPDATE 12'h0c4
`define OFS_USB_CLOCK_DIVIDER 12'h0c8
`define OFS_WDT_SOURCE_SELECT 12'h0d0
`define OFS_WDT_SOURCE_UPDATE 12'h0d4
`define OFS_CLOCK_OUTPUT_PIN_SOURCE_SELECT 12'h0e0
`define OFS_CLOCK_OUTPUT_PIN_SOURCE_UPDATE 12'h0e4
`define OFS_BROWNOUT_CONTROL 12'h150
`define OFS_WAKE_ENABLE 12'h204
`define OFS_DEEP_SLEEP_POWER_CONFIG 12'h230
`define OFS_WAKE_POWER_CONFIG 12'h234
`define OFS_RUN_POWER_CONFIG 12'h238
`define OFS_IRQ_STATUS 12'h300
`define OFS_IRQ_MASK 12'h304
`define RST_BUS_CLOCK_GATING 32'h0000485f
`define RST_WAKE_POWER_CONFIG 32'h0000fdf0
`define RST_RUN_POWER_CONFIG 32'h0000edf0
`define BIT_GATE_USB 14
`define BIT_GATE_UART 12
`define USB_PD_MASK 32'h00000500
`define WAKE_ENABLE_SMALL_MASK 32'h00000000
`define IRQ_BROWNOUT 0
`define IRQ_MAIN_SWITCH 1
`define IRQ_UART_ORDER 2
`endif

// [include/clock_config_pkg.sv]
package clock_config_pkg;
  typedef enum logic [1:0] {
    MAIN_IRC = 2'b00,
    MAIN_PLL_IN = 2'b01,
    MAIN_WDT_OSC = 2'b10,
    MAIN_PLL_OUT = 2'b11
  } main_src_e;
  typedef enum logic [1:0] {
    OUT_IRC = 2'b00,
    OUT_SYS_OSC = 2'b01,
    OUT_WDT_OSC = 2'b10,
    OUT_MAIN = 2'b11
  } out_src_e;
endpackage

// [rtl/system_clock_config.sv]
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "clock_config_defs.svh"
module system_clock_config
  import clock_config_pkg::*;
#(
  parameter bit HAS_USB = 1'b1,
  parameter bit LOW_POWER = 1'b0,
  parameter logic [31:0] WAKE_BONDED_MASK = 32'hffffffff
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // oscillator clocks and brownout level, sampled
  input wire logic sys_osc_in,
  input wire logic irc_osc_in,
  input wire logic wdt_osc_in,
  input wire logic pll_out_in,
  input wire logic brownout_level_in,
  // avalon-mm slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // clock outputs
  output logic main_clk_out,
  output logic [31:0] bus_clk_en,
  output logic uart_clk,
  output logic ssp0_clk,
  output logic ssp1_clk,
  output logic tick_clk,
  output logic trace_clk,
  output logic usb_clk,
  output logic wdt_clk,
  output logic clock_output_pin,
  // power and brownout
  output logic [31:0] run_pd,
  output logic [31:0] sleep_pd,
  output logic [31:0] wake_pd,
  output logic brownout_reset_out,
  output logic [31:0] wake_enable,
  output logic irq
);
  logic [2:0] sys_s, irc_s, wdt_s, pll_s, bod_s;
  logic sys_c, irc_c, wdt_c, pll_c, bod_c;
  always_ff @(posedge clk) begin
    sys_s <= {sys_s[1:0], sys_osc_in};
    irc_s <= {irc_s[1:0], irc_osc_in};
    wdt_s <= {wdt_s[1:0], wdt_osc_in};
    pll_s <= {pll_s[1:0], pll_out_in};
    bod_s <= {bod_s[1:0], brownout_level_in};
  end
  // change counted once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_s[1] == sys_s[2]) sys_c <= sys_s[2];
    if (irc_s[1] == irc_s[2]) irc_c <= irc_s[2];
    if (wdt_s[1] == wdt_s[2]) wdt_c <= wdt_s[2];
    if (pll_s[1] == pll_s[2]) pll_c <= pll_s[2];
    if (bod_s[1] == bod_s[2]) bod_c <= bod_s[2];
  end
  logic [1:0] main_sel_reg, main_act_reg, usbpll_sel_reg, usbpll_act_reg;
  logic [1:0] usb_sel_reg, usb_act_reg, wdt_sel_reg, wdt_act_reg, out_sel_reg, out_act_reg;
  logic main_upd_reg, usbpll_upd_reg, usb_upd_reg, wdt_upd_reg, out_upd_reg;
  logic [31:0] gate_reg, usbpll_ctl_reg, sleep_reg, wake_reg, run_reg, wake_en_reg;
  logic [7:0] div_uart_reg, div_ssp0_reg, div_ssp1_reg, div_tick_reg, div_trace_reg, div_usb_reg;
  logic [3:0] bod_ctl_reg;
  logic [2:0] irq_stat_reg, irq_mask_reg;
  logic wr, rd, ack_reg, uart_gate_old;
  logic [31:0] wmask;
  assign wr = avs_write && !ack_reg && avs_byteenable == 4'hf && avs_address[1:0] == 2'b00;
  assign rd = avs_read && !ack_reg;
  assign wmask = HAS_USB ? 32'hffffffff : ~`USB_PD_MASK;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_sel_reg <= 2'h0;
      usbpll_sel_reg <= 2'h0;
      usb_sel_reg <= 2'h0;
      wdt_sel_reg <= 2'h0;
      out_sel_reg <= 2'h0;
      main_upd_reg <= 1'b0;
      usbpll_upd_reg <= 1'b0;
      usb_upd_reg <= 1'b0;
      wdt_upd_reg <= 1'b0;
      out_upd_reg <= 1'b0;
      usbpll_ctl_reg <= 32'h0;
      gate_reg <= `RST_BUS_CLOCK_GATING;
      sleep_reg <= 32'h0;
      wake_reg <= `RST_WAKE_POWER_CONFIG;
      run_reg <= `RST_RUN_POWER_CONFIG;
      wake_en_reg <= 32'h0;
      div_uart_reg <= 8'h0;
      div_ssp0_reg <= 8'h0;
      div_ssp1_reg <= 8'h0;
      div_tick_reg <= 8'h0;
      div_trace_reg <= 8'h0;
      div_usb_reg <= 8'h0;
      bod_ctl_reg <= 4'h0;
      irq_mask_reg <= 3'h0;
    end else if (wr) begin
      unique case (avs_address)
        `OFS_MAIN_SOURCE_SELECT: main_sel_reg <= avs_writedata[1:0];
        `OFS_MAIN_SOURCE_UPDATE: main_upd_reg <= avs_writedata[0];
        `OFS_WDT_SOURCE_SELECT: wdt_sel_reg <= avs_writedata[1:0];
        `OFS_WDT_SOURCE_UPDATE: wdt_upd_reg <= avs_writedata[0];
        `OFS_CLOCK_OUTPUT_PIN_SOURCE_SELECT: out_sel_reg <= avs_writedata[1:0];
        `OFS_CLOCK_OUTPUT_PIN_SOURCE_UPDATE: out_upd_reg <= avs_writedata[0];
        `OFS_USB_PLL_CONTROL: if (HAS_USB) usbpll_ctl_reg <= avs_writedata;
        `OFS_USB_PLL_SOURCE_SELECT: if (HAS_USB) usbpll_sel_reg <= avs_writedata[1:0];
        `OFS_USB_PLL_SOURCE_UPDATE: if (HAS_USB) usbpll_upd_reg <= avs_writedata[0];
        `OFS_USB_CLOCK_SOURCE_SELECT: if (HAS_USB) usb_sel_reg <= avs_writedata[1:0];
        `OFS_USB_CLOCK_SOURCE_UPDATE: if (HAS_USB) usb_upd_reg <= avs_writedata[0];
        `OFS_USB_CLOCK_DIVIDER: if (HAS_USB) div_usb_reg <= avs_writedata[7:0];
        `OFS_BUS_CLOCK_GATING: gate_reg <= HAS_USB ? avs_writedata : (avs_writedata & ~(32'h1 << `BIT_GATE_USB));
        `OFS_UART_DIVIDER: div_uart_reg <= avs_writedata[7:0];
        `OFS_SSP0_DIVIDER: div_ssp0_reg <= avs_writedata[7:0];
        `OFS_SSP1_DIVIDER: div_ssp1_reg <= avs_writedata[7:0];
        `OFS_TICK_DIVIDER: div_tick_reg <= avs_writedata[7:0];
        `OFS_TRACE_DIVIDER: div_trace_reg <= avs_writedata[7:0];
        `OFS_BROWNOUT_CONTROL: bod_ctl_reg <= LOW_POWER ? avs_writedata[3:0] : {2'b00, avs_writedata[3:2]};
        `OFS_WAKE_ENABLE: wake_en_reg <= avs_writedata & WAKE_BONDED_MASK;
        `OFS_DEEP_SLEEP_POWER_CONFIG: sleep_reg <= avs_writedata & wmask;
        `OFS_WAKE_POWER_CONFIG: wake_reg <= (avs_writedata & wmask) | (`RST_WAKE_POWER_CONFIG & ~wmask);
        `OFS_RUN_POWER_CONFIG: run_reg <= (avs_writedata & wmask) | (`RST_RUN_POWER_CONFIG & ~wmask);
        `OFS_IRQ_MASK: irq_mask_reg <= avs_writedata[2:0];
        default: ;
      endcase
    end
  end
  // select applied on update rising edge
  logic main_upd_d, usbpll_upd_d, usb_upd_d, wdt_upd_d, out_upd_d;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_upd_d <= 1'b0;
      usbpll_upd_d <= 1'b0;
      usb_upd_d <= 1'b0;
      wdt_upd_d <= 1'b0;
      out_upd_d <= 1'b0;
      main_act_reg <= MAIN_IRC;
      usbpll_act_reg <= 2'h0;
      usb_act_reg <= 2'h0;
      wdt_act_reg <= 2'h0;
      out_act_reg <= OUT_IRC;
    end else begin
      main_upd_d <= main_upd_reg;
      usbpll_upd_d <= usbpll_upd_reg;
      usb_upd_d <= usb_upd_reg;
      wdt_upd_d <= wdt_upd_reg;
      out_upd_d <= out_upd_reg;
      if (main_upd_reg && !main_upd_d) main_act_reg <= main_sel_reg;
      if (usbpll_upd_reg && !usbpll_upd_d) usbpll_act_reg <= usbpll_sel_reg;
      if (usb_upd_reg && !usb_upd_d) usb_act_reg <= usb_sel_reg;
      if (wdt_upd_reg && !wdt_upd_d) wdt_act_reg <= wdt_sel_reg;
      if (out_upd_reg && !out_upd_d) out_act_reg <= out_sel_reg;
    end
  end
  logic main_c, usb_src, wdt_src, out_src;
  always_comb begin
    unique case (main_src_e'(main_act_reg))
      MAIN_IRC: main_c = irc_c;
      MAIN_PLL_IN: main_c = sys_c;
      MAIN_WDT_OSC: main_c = wdt_c;
      MAIN_PLL_OUT: main_c = pll_c;
    endcase
  end
  assign usb_src = usb_act_reg[0] ? main_c : (usbpll_act_reg[0] ? irc_c : sys_c);
  assign wdt_src = (wdt_act_reg == 2'h0) ? irc_c : ((wdt_act_reg == 2'h1) ? main_c : wdt_c);
  always_comb begin
    unique case (out_src_e'(out_act_reg))
      OUT_IRC: out_src = irc_c;
      OUT_SYS_OSC: out_src = sys_c;
      OUT_WDT_OSC: out_src = wdt_c;
      OUT_MAIN: out_src = main_c;
    endcase
  end
  // per-peripheral dividers, zero stops the clock
  logic [7:0] src_sel [6];
  logic [6:0] div_q, src_vec, src_d;
  logic [7:0] cnt [7];
  assign src_sel[0] = div_uart_reg;
  assign src_sel[1] = div_ssp0_reg;
  assign src_sel[2] = div_ssp1_reg;
  assign src_sel[3] = div_tick_reg;
  assign src_sel[4] = div_trace_reg;
  assign src_sel[5] = HAS_USB ? div_usb_reg : 8'h0;
  assign src_vec = {wdt_src, usb_src, main_c, main_c, main_c, main_c, main_c};
  always_ff @(posedge clk) begin
    if (sys_rst) src_d <= 7'h0;
    else src_d <= src_vec;
  end
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : gen_div
      logic [7:0] dv;
      assign dv = (g == 6) ? 8'h1 : src_sel[(g == 6) ? 0 : g];
      always_ff @(posedge clk) begin
        if (sys_rst || dv == 8'h0) begin
          cnt[g] <= 8'h0;
          div_q[g] <= 1'b0;
        end else if (src_vec[g] && !src_d[g]) begin
          if (cnt[g] + 8'h1 >= dv) begin
            cnt[g] <= 8'h0;
            div_q[g] <= ~div_q[g];
          end else begin
            cnt[g] <= cnt[g] + 8'h1;
          end
        end
      end
    end
  endgenerate
  // brownout: level compare via synchronised trip
  logic bod_irq_d;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brownout_reset_out <= 1'b0;
      bod_irq_d <= 1'b0;
    end else begin
      brownout_reset_out <= bod_c && bod_ctl_reg[1:0] == 2'h0 && bod_ctl_reg[3:2] != 2'h3;
      bod_irq_d <= bod_c;
    end
  end
  // sticky events, set wins over clear
  logic [2:0] ev;
  assign ev[`IRQ_BROWNOUT] = bod_c && !bod_irq_d;
  assign ev[`IRQ_MAIN_SWITCH] = main_upd_reg && !main_upd_d;
  // flags uart gate turned on, order check left to software
  assign ev[`IRQ_UART_ORDER] = gate_reg[`BIT_GATE_UART] && !uart_gate_old;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_reg <= 3'h0;
      uart_gate_old <= 1'b0;
    end else begin
      uart_gate_old <= gate_reg[`BIT_GATE_UART];
      irq_stat_reg <= (irq_stat_reg & ~((wr && avs_address == `OFS_IRQ_STATUS) ? avs_writedata[2:0] : 3'h0)) | ev;
    end
  end
  logic [31:0] rdata;
  logic mapped;
  always_comb begin
    rdata = 32'h0;
    mapped = 1'b1;
    unique case (avs_address)
      `OFS_MAIN_SOURCE_SELECT: rdata = {30'h0, main_sel_reg};
      `OFS_MAIN_SOURCE_UPDATE: rdata = {31'h0, main_upd_reg};
      `OFS_WDT_SOURCE_SELECT: rdata = {30'h0, wdt_sel_reg};
      `OFS_WDT_SOURCE_UPDATE: rdata = {31'h0, wdt_upd_reg};
      `OFS_CLOCK_OUTPUT_PIN_SOURCE_SELECT: rdata = {30'h0, out_sel_reg};
      `OFS_CLOCK_OUTPUT_PIN_SOURCE_UPDATE: rdata = {31'h0, out_upd_reg};
      `OFS_USB_PLL_CONTROL: rdata = usbpll_ctl_reg;
      `OFS_USB_PLL_STATUS: rdata = {31'h0, HAS_USB & pll_c};
      `OFS_USB_PLL_SOURCE_SELECT: rdata = {30'h0, usbpll_sel_reg};
      `OFS_USB_PLL_SOURCE_UPDATE: rdata = {31'h0, usbpll_upd_reg};
      `OFS_USB_CLOCK_SOURCE_SELECT: rdata = {30'h0, usb_sel_reg};
      `OFS_USB_CLOCK_SOURCE_UPDATE: rdata = {31'h0, usb_upd_reg};
      `OFS_USB_CLOCK_DIVIDER: rdata = {24'h0, div_usb_reg};
      `OFS_BUS_CLOCK_GATING: rdata = gate_reg;
      `OFS_UART_DIVIDER: rdata = {24'h0, div_uart_reg};
      `OFS_SSP0_DIVIDER: rdata = {24'h0, div_ssp0_reg};
      `OFS_SSP1_DIVIDER: rdata = {24'h0, div_ssp1_reg};
      `OFS_TICK_DIVIDER: rdata = {24'h0, div_tick_reg};
      `OFS_TRACE_DIVIDER: rdata = {24'h0, div_trace_reg};
      `OFS_BROWNOUT_CONTROL: rdata = {28'h0, bod_ctl_reg};
      `OFS_WAKE_ENABLE: rdata = wake_en_reg;
      `OFS_DEEP_SLEEP_POWER_CONFIG: rdata = sleep_reg;
      `OFS_WAKE_POWER_CONFIG: rdata = wake_reg;
      `OFS_RUN_POWER_CONFIG: rdata = run_reg;
      `OFS_IRQ_STATUS: rdata = {29'h0, irq_stat_reg};
      `OFS_IRQ_MASK: rdata = {29'h0, irq_mask_reg};
      default: mapped = 1'b0;
    endcase
  end
  // answer one cycle after request; unmapped reads zero with slave error
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
      avs_response <= 2'b00;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      avs_readdata <= rd ? rdata : 32'h0;
      avs_response <= ((avs_read || avs_write) && !ack_reg && !mapped) ? 2'b10 : 2'b00;
    end
  end
  // rc power bit is software's duty; outputs straight from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_clk_out <= 1'b0;
      bus_clk_en <= `RST_BUS_CLOCK_GATING;
      uart_clk <= 1'b0;
      ssp0_clk <= 1'b0;
      ssp1_clk <= 1'b0;
      tick_clk <= 1'b0;
      trace_clk <= 1'b0;
      usb_clk <= 1'b0;
      wdt_clk <= 1'b0;
      clock_output_pin <= 1'b0;
      run_pd <= `RST_RUN_POWER_CONFIG;
      sleep_pd <= 32'h0;
      wake_pd <= `RST_WAKE_POWER_CONFIG;
      wake_enable <= 32'h0;
      irq <= 1'b0;
    end else begin
      main_clk_out <= main_c;
      bus_clk_en <= gate_reg;
      uart_clk <= div_q[0] & gate_reg[`BIT_GATE_UART];
      ssp0_clk <= div_q[1];
      ssp1_clk <= div_q[2];
      tick_clk <= div_q[3];
      trace_clk <= div_q[4];
      usb_clk <= div_q[5];
      wdt_clk <= div_q[6];
      clock_output_pin <= out_src;
      run_pd <= run_reg;
      sleep_pd <= sleep_reg;
      wake_pd <= wake_reg;
      wake_enable <= wake_en_reg;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// [test/system_clock_config_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "clock_config_defs.svh"
module system_clock_config_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // configuration outputs
  input wire logic [31:0] bus_clk_en,
  input wire logic [31:0] run_pd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic gate_wr;
  assign req = avs_read || avs_write;
  // only the taken edge counts, the ack cycle must not store twice
  assign gate_wr = avs_write && avs_waitrequest && avs_address == `OFS_BUS_CLOCK_GATING;
  property p_rst_val;
    disable iff (1'b0) sys_rst |=> avs_waitrequest && bus_clk_en == `RST_BUS_CLOCK_GATING
      && run_pd == `RST_RUN_POWER_CONFIG;
  endproperty
  property p_ack_next;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_ack_cause;
    !avs_waitrequest |-> $past(req);
  endproperty
  property p_unmapped;
    !avs_waitrequest && avs_read && avs_address == 12'h3f0 |-> avs_response == 2'b10 && avs_readdata == 32'h0;
  endproperty
  property p_gate_wr;
    gate_wr && avs_byteenable == 4'hf |-> ##2 bus_clk_en == $past(avs_writedata, 2);
  endproperty
  property p_gate_part;
    gate_wr && avs_byteenable != 4'hf |=> $stable(bus_clk_en) [*2];
  endproperty
  property p_gate_rd;
    !avs_waitrequest && avs_read && avs_address == `OFS_BUS_CLOCK_GATING |-> avs_response == 2'b00
      && avs_readdata == bus_clk_en;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  a_ack_next: assert property (p_ack_next) else $error("no answer after one wait");
  a_ack_one: assert property (p_ack_one) else $error("answer longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered wrong");
  a_gate_wr: assert property (p_gate_wr) else $error("gating write not applied");
  a_gate_part: assert property (p_gate_part) else $error("partial write changed gating");
  a_gate_rd: assert property (p_gate_rd) else $error("gating readback differs");
  c_unmapped: cover property (!avs_waitrequest && avs_read && avs_address == 12'h3f0);
  c_partial: cover property (gate_wr && avs_byteenable != 4'hf);
  c_gate_rd: cover property (!avs_waitrequest && avs_read && avs_address == `OFS_BUS_CLOCK_GATING);
endmodule
bind system_clock_config system_clock_config_chk system_clock_config_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .bus_clk_en(bus_clk_en), .run_pd(run_pd));
`default_nettype wire

// [test/system_clock_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "clock_config_defs.svh"
module system_clock_config_tb
  import clock_config_pkg::*;
();
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sys_osc = 1'b0;
  logic internal_rc_oscillator = 1'b0;
  logic wdt = 1'b0;
  logic bo = 1'b0;
  logic [11:0] addr = 12'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] readdata, bus_en, run_pd, sleep_pd, wake_pd;
  logic [1:0] resp;
  logic waitreq, main_clk, uart, pin, irq;
  int n_mismatch = 0;
  int check_count = 0;
  system_clock_config system_clock_config_inst (.clk(clk), .sys_rst(sys_rst), .sys_osc_in(sys_osc),
    .irc_osc_in(internal_rc_oscillator), .wdt_osc_in(wdt), .pll_out_in(1'b0), .brownout_level_in(bo), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(readdata),
    .avs_waitrequest(waitreq), .avs_response(resp), .main_clk_out(main_clk), .bus_clk_en(bus_en),
    .uart_clk(uart), .ssp0_clk(), .ssp1_clk(), .tick_clk(), .trace_clk(), .usb_clk(), .wdt_clk(),
    .clock_output_pin(pin), .run_pd(run_pd), .sleep_pd(sleep_pd), .wake_pd(wake_pd),
    .brownout_reset_out(), .wake_enable(), .irq(irq));
  initial begin
    forever #50 clk = !clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // first edge spent on entry so a release and a new request never share a time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q, output logic [1:0] r);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    q = readdata;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b1, a, d, 4'hf, q, r);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b0, a, 32'h0, 4'hf, q, r);
    check("readdata", q, exp);
    check("response", 32'(r), 32'h0);
  endtask
  // update takes a 0 then 1, a lone 1 may already be stored
  task automatic upd(input logic [11:0] a);
    wr32(a, 32'h0);
    wr32(a, 32'h1);
  endtask
  task automatic t_reset();
    check("bus_clk_en", bus_en, `RST_BUS_CLOCK_GATING);
    check("run_pd", run_pd, `RST_RUN_POWER_CONFIG);
    check("wake_pd", wake_pd, `RST_WAKE_POWER_CONFIG);
    check("sleep_pd", sleep_pd, 32'h0);
    check("irq", 32'(irq), 32'h0);
    rd_chk(`OFS_BUS_CLOCK_GATING, `RST_BUS_CLOCK_GATING);
    rd_chk(`OFS_MAIN_SOURCE_SELECT, 32'h0);
  endtask
  task automatic t_main();
    internal_rc_oscillator <= 1'b1;
    wait_cyc(8);
    check("main_clk", 32'(main_clk), 32'h1);
    wr32(`OFS_MAIN_SOURCE_SELECT, 32'(MAIN_WDT_OSC));
    wait_cyc(8);
    check("main_clk", 32'(main_clk), 32'h1);
    upd(`OFS_MAIN_SOURCE_UPDATE);
    wait_cyc(8);
    check("main_clk", 32'(main_clk), 32'h0);
    wdt <= 1'b1;
    wait_cyc(8);
    check("main_clk", 32'(main_clk), 32'h1);
    rd_chk(`OFS_IRQ_STATUS, 32'h2);
  endtask
  task automatic t_clock_output_pin();
    int s;
    logic v;
    for (s = 0; s < 4; s++) begin
      wr32(`OFS_CLOCK_OUTPUT_PIN_SOURCE_SELECT, 32'(s));
      upd(`OFS_CLOCK_OUTPUT_PIN_SOURCE_UPDATE);
      v = 1'b1;
      repeat (2) begin
        // main runs from the watchdog source here, so it follows wdt too
        internal_rc_oscillator <= (s == 0) ? v : !v;
        sys_osc <= (s == 1) ? v : !v;
        wdt <= (s >= 2) ? v : !v;
        wait_cyc(8);
        check("clock_output_pin", 32'(pin), 32'(v));
        v = !v;
      end
    end
  endtask
  task automatic t_irq();
    // uart pins counted as set up before this gate write
    wr32(`OFS_BUS_CLOCK_GATING, 32'h0000185f);
    wait_cyc(1);
    check("bus_clk_en", bus_en, 32'h0000185f);
    rd_chk(`OFS_IRQ_STATUS, 32'h6);
    check("irq", 32'(irq), 32'h0);
    wr32(`OFS_IRQ_MASK, 32'h4);
    wait_cyc(2);
    check("irq", 32'(irq), 32'h1);
    wr32(`OFS_IRQ_STATUS, 32'h4);
    wait_cyc(2);
    check("irq", 32'(irq), 32'h0);
    wr32(`OFS_IRQ_MASK, 32'h1);
    bo <= 1'b1;
    wait_cyc(8);
    check("irq", 32'(irq), 32'h1);
    wr32(`OFS_IRQ_STATUS, 32'h3);
    bo <= 1'b0;
    wait_cyc(2);
    check("irq", 32'(irq), 32'h0);
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
  endtask
  task automatic t_bus();
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b1, `OFS_BUS_CLOCK_GATING, 32'h0, 4'h3, q, r);
    check("bus_clk_en", bus_en, 32'h0000185f);
    xfer(1'b0, 12'h3f0, 32'h0, 4'hf, q, r);
    check("response", 32'(r), 32'h2);
    check("readdata", q, 32'h0);
    // no deep power-down entered, rc oscillator left as is
    wr32(`OFS_RUN_POWER_CONFIG, 32'h0000ed00);
    rd_chk(`OFS_RUN_POWER_CONFIG, 32'h0000ed00);
    check("run_pd", run_pd, 32'h0000ed00);
  endtask
  task automatic count_uart(output int n);
    int i;
    logic prev;
    n = 0;
    prev = uart;
    for (i = 0; i < 80; i++) begin
      @(posedge clk);
      wdt <= i[2];
      if (uart === 1'b1 && prev === 1'b0) n++;
      prev = uart;
    end
  endtask
  task automatic t_div();
    int n;
    wr32(`OFS_UART_DIVIDER, 32'h0);
    count_uart(n);
    check("uart_rises", 32'(n), 32'h0);
    wr32(`OFS_UART_DIVIDER, 32'h1);
    count_uart(n);
    // sampling latency blurs one edge at either end of the window
    check("uart_rises_in_range", 32'(n >= 4 && n <= 6), 32'h1);
  endtask
  task automatic t_rerst();
    @(posedge clk);
    sys_rst <= 1'b1;
    internal_rc_oscillator <= 1'b1;
    wdt <= 1'b0;
    wait_cyc(3);
    sys_rst <= 1'b0;
    wait_cyc(8);
    check("main_clk", 32'(main_clk), 32'h1);
    check("bus_clk_en", bus_en, `RST_BUS_CLOCK_GATING);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_main();
    t_clock_output_pin();
    t_irq();
    t_bus();
    t_div();
    t_rerst();
    test_done();
  end
endmodule
`default_nettype wire
